// *** hw/sac_pkg.sv ***
package sac_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int SAC_ADDR_W = 4;
    localparam int SAC_DATA_W = 16;
    localparam int SAC_RES_W  = 10;
    localparam int SAC_ACC_W  = 3;
    localparam int SAC_DIV_W  = 3;
    localparam int SAC_REF_W  = 2;
    localparam int SAC_SDLY_W = 4;
    localparam int SAC_SLEN_W = 5;
    localparam int SAC_CH_W   = 5;
    localparam int SAC_PCNT_W = 9;
    localparam int SAC_CYC_W  = 6;
    localparam int SAC_NSMP_W = 7;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [SAC_ADDR_W-1:0] SAC_OFS_CTRL    = 4'h0;
    localparam logic [SAC_ADDR_W-1:0] SAC_OFS_ACCUM   = 4'h1;
    localparam logic [SAC_ADDR_W-1:0] SAC_OFS_DIVIDER = 4'h2;
    localparam logic [SAC_ADDR_W-1:0] SAC_OFS_REFSRC  = 4'h3;
    localparam logic [SAC_ADDR_W-1:0] SAC_OFS_SDELAY  = 4'h4;
    localparam logic [SAC_ADDR_W-1:0] SAC_OFS_SLENGTH = 4'h5;
    localparam logic [SAC_ADDR_W-1:0] SAC_OFS_CHANNEL = 4'h6;
    localparam logic [SAC_ADDR_W-1:0] SAC_OFS_COMMAND = 4'h7;
    localparam logic [SAC_ADDR_W-1:0] SAC_OFS_EVENT   = 4'h8;
    localparam logic [SAC_ADDR_W-1:0] SAC_OFS_INTEN   = 4'h9;
    localparam logic [SAC_ADDR_W-1:0] SAC_OFS_FLAGS   = 4'hA;
    localparam logic [SAC_ADDR_W-1:0] SAC_OFS_RESULT  = 4'hB;
    localparam logic [SAC_ADDR_W-1:0] SAC_OFS_STATUS  = 4'hC;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SAC_CTRL_EN_BIT     = 0;
    localparam int SAC_CTRL_CONT_BIT   = 1;
    localparam int SAC_CTRL_RES8_BIT   = 2;
    localparam int SAC_CTRL_DEBUG_KEEP_RUNNING_BIT = 3;
    localparam int SAC_STAT_CH_LSB     = 8;

    // ****************************************************************
    // Timing constants and limits
    // ****************************************************************
    localparam logic [SAC_CYC_W-1:0]  SAC_SAMPLE_BASE = 6'h02;
    localparam logic [SAC_CYC_W-1:0]  SAC_SAR_CYC     = 6'h0B;
    localparam logic [SAC_ACC_W-1:0]  SAC_ACC_MAX     = 3'h6;
    localparam logic [SAC_PCNT_W-1:0] SAC_DIV_HALF_MIN = 9'h002;
    localparam logic [SAC_RES_W-1:0]  SAC_RES_MAX     = 10'h3FF;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_WAIT = 2'b01,
        SAC_CONV = 2'b11
    } sac_phase_t;

    typedef struct packed {
        logic [SAC_ADDR_W-1:0] addr;
        logic [SAC_DATA_W-1:0] wdata;
        logic                  wr;
        logic                  rd;
    } sac_bus_req_t;

    typedef struct packed {
        logic                 enable;
        logic                 sample;
        logic [SAC_RES_W-1:0] trial;
        logic [SAC_CH_W-1:0]  channel;
        logic [SAC_REF_W-1:0] reference;
    } sac_analog_t;

    typedef struct packed {
        logic                  enable;
        logic                  continuous_mode;
        logic                  resolution_select;
        logic                  debug_keep_running;
        logic [SAC_ACC_W-1:0]  accumulation_count;
        logic [SAC_DIV_W-1:0]  clock_divider_select;
        logic [SAC_REF_W-1:0]  reference_select;
        logic [SAC_SDLY_W-1:0] sample_delay;
        logic [SAC_SLEN_W-1:0] sample_length;
        logic [SAC_CH_W-1:0]   input_channel_select;
        logic                  event_start_enable;
        logic                  ready_int_enable;
    } sac_cfg_t;

    typedef struct packed {
        sac_cfg_t              cfg;
        sac_phase_t            phase;
        logic                  start_conversion_cmd;
        logic                  result_ready_flag;
        logic [SAC_DATA_W-1:0] conversion_result;
        logic [SAC_DATA_W-1:0] acc;
        logic [SAC_PCNT_W-1:0] pcnt;
        logic [SAC_CYC_W-1:0]  cyc;
        logic [SAC_NSMP_W-1:0] nsamp;
        logic [SAC_RES_W-1:0]  sar;
        logic [SAC_CH_W-1:0]   ch_act;
        logic [SAC_REF_W-1:0]  ref_act;
        logic                  sample;
        logic [SAC_DATA_W-1:0] rd_data;
        logic                  irq;
        logic                  ev_s1;
        logic                  ev_s2;
        logic                  ev_prev;
        logic                  cmp_s1;
        logic                  cmp_s2;
    } sac_state_t;

    localparam sac_state_t SAC_STATE_RST = '0;

endpackage

// *** hw/sac_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Writing one to start begins a conversion; bit stays one, single mode clears it.
// - A channel change during a conversion waits until that conversion finishes.
// - Result ready is set when the single sample or whole accumulation finishes.
// - Interrupt request only when flag set, enable one and global enable one.
// - Flag is set on completion even with its interrupt disabled.
// - With event start enabled, an incoming event triggers a conversion unless one is already pending or running.
// - Event input is edge sensitive and sets the start bit, which single mode clears at completion.
// - Continuous mode: software starts first, later conversions follow immediately, each sets ready.
// - Prescaler counts while a conversion waits or runs, holds during debug halt, and is held at zero while idle.
// - Conversion starts on next converter clock edge; latency half divider plus two.
// - Normal conversion is 13 converter cycles, capture two cycles after start.
// - Completion loads result and sets flag; read of result or writing one clears it.
// - Sampling phase lasts two plus sample delay plus sample length cycles.
// - Back-to-back continuous conversions take 13 plus delay plus length cycles.
// - Channel and reference are shadowed and copied continuously while no conversion runs.
// - Active selection frozen during conversion; updates resume in its final cycle.
// - Input above reference gives the full-scale code 0x3FF.
// - Debug halt stops the converter unless debug keep running is set.
// - The ten-bit result is right aligned in the result register.
// - Channel and reference selections take effect only once enabled.
module sac_ctrl (
    // Clock and reset.
    input  wire  logic                                clk_sys_in,
    input  wire  logic                                reset_in,
    // Register port.
    input  wire  sac_pkg::sac_bus_req_t               bus_in,
    output logic [sac_pkg::SAC_DATA_W-1:0]            rd_data_out,
    // System signals.
    input  wire  logic                                event_in,
    input  wire  logic                                global_int_enable_in,
    input  wire  logic                                debug_halt_in,
    output logic                                      irq_out,
    // Analog core.
    input  wire  logic                                cmp_in,
    output var   sac_pkg::sac_analog_t                analog_out
);
    import sac_pkg::*;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Half of the converter clock division factor, which runs from 4 to 512.
    function automatic logic [SAC_PCNT_W-1:0] div_half(input logic [SAC_DIV_W-1:0] sel);
        div_half = SAC_DIV_HALF_MIN << sel;
    endfunction

    // Index of the last sample of one accumulation sequence.
    function automatic logic [SAC_NSMP_W-1:0] last_sample(input logic [SAC_ACC_W-1:0] n);
        logic [SAC_ACC_W-1:0] c;
        c = (n > SAC_ACC_MAX) ? SAC_ACC_MAX : n;
        last_sample = SAC_NSMP_W'((8'h01 << c) - 8'h01);
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    sac_state_t              s_ff;
    sac_state_t              nxt_s;
    logic                    run;
    logic                    tick;
    logic                    pre_tick;
    logic                    ev_edge;
    logic                    done;
    logic                    lock;
    logic [SAC_PCNT_W-1:0]   half;
    logic [SAC_PCNT_W-1:0]   wrap;
    logic [SAC_CYC_W-1:0]    samp_len;
    logic [SAC_CYC_W-1:0]    last_cyc;
    logic [SAC_CYC_W-1:0]    cyc_next;
    logic [3:0]              bpos_cur;
    logic [3:0]              bpos_next;
    logic [SAC_DATA_W-1:0]   sum;

    always_comb begin
        nxt_s    = s_ff;
        done     = 1'b0;
        half     = div_half(s_ff.cfg.clock_divider_select);
        wrap     = SAC_PCNT_W'((10'(half) << 1) - 10'h001);
        samp_len = SAC_SAMPLE_BASE + SAC_CYC_W'(s_ff.cfg.sample_delay)
                   + SAC_CYC_W'(s_ff.cfg.sample_length);
        last_cyc = samp_len + SAC_SAR_CYC - 6'h01;
        cyc_next = s_ff.cyc + 6'h01;
        bpos_cur  = 4'h9 - 4'(s_ff.cyc - samp_len);
        bpos_next = 4'h9 - 4'(cyc_next - samp_len);
        sum      = s_ff.acc + SAC_DATA_W'(s_ff.sar);
        run      = !(debug_halt_in && !s_ff.cfg.debug_keep_running);
        tick     = run && (s_ff.phase != SAC_IDLE) && (s_ff.pcnt == half);
        pre_tick = run && (s_ff.pcnt == half - 9'h001);

        // ****************************************************************
        // Synchronisers
        // ****************************************************************
        nxt_s.ev_s1   = event_in;
        nxt_s.ev_s2   = s_ff.ev_s1;
        nxt_s.ev_prev = s_ff.ev_s2;
        nxt_s.cmp_s1  = cmp_in;
        nxt_s.cmp_s2  = s_ff.cmp_s1;
        ev_edge       = s_ff.ev_s2 && !s_ff.ev_prev;

        // ****************************************************************
        // Register writes
        // ****************************************************************
        if (bus_in.wr) begin
            case (bus_in.addr)
                SAC_OFS_CTRL: begin
                    nxt_s.cfg.enable             = bus_in.wdata[SAC_CTRL_EN_BIT];
                    nxt_s.cfg.continuous_mode    = bus_in.wdata[SAC_CTRL_CONT_BIT];
                    nxt_s.cfg.resolution_select  = bus_in.wdata[SAC_CTRL_RES8_BIT];
                    nxt_s.cfg.debug_keep_running = bus_in.wdata[SAC_CTRL_DEBUG_KEEP_RUNNING_BIT];
                end
                SAC_OFS_ACCUM:   nxt_s.cfg.accumulation_count   = bus_in.wdata[SAC_ACC_W-1:0];
                SAC_OFS_DIVIDER: nxt_s.cfg.clock_divider_select = bus_in.wdata[SAC_DIV_W-1:0];
                SAC_OFS_REFSRC:  nxt_s.cfg.reference_select     = bus_in.wdata[SAC_REF_W-1:0];
                SAC_OFS_SDELAY:  nxt_s.cfg.sample_delay         = bus_in.wdata[SAC_SDLY_W-1:0];
                SAC_OFS_SLENGTH: nxt_s.cfg.sample_length        = bus_in.wdata[SAC_SLEN_W-1:0];
                SAC_OFS_CHANNEL: nxt_s.cfg.input_channel_select = bus_in.wdata[SAC_CH_W-1:0];
                SAC_OFS_COMMAND: begin
                    if (bus_in.wdata[0] && s_ff.cfg.enable) begin
                        nxt_s.start_conversion_cmd = 1'b1;
                    end
                end
                SAC_OFS_EVENT:   nxt_s.cfg.event_start_enable = bus_in.wdata[0];
                SAC_OFS_INTEN:   nxt_s.cfg.ready_int_enable   = bus_in.wdata[0];
                SAC_OFS_FLAGS: begin
                    if (bus_in.wdata[0]) begin
                        nxt_s.result_ready_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // ****************************************************************
        // Register reads
        // ****************************************************************
        nxt_s.rd_data = '0;
        if (bus_in.rd) begin
            case (bus_in.addr)
                SAC_OFS_CTRL:    nxt_s.rd_data = SAC_DATA_W'({s_ff.cfg.debug_keep_running,
                                                  s_ff.cfg.resolution_select,
                                                  s_ff.cfg.continuous_mode, s_ff.cfg.enable});
                SAC_OFS_ACCUM:   nxt_s.rd_data = SAC_DATA_W'(s_ff.cfg.accumulation_count);
                SAC_OFS_DIVIDER: nxt_s.rd_data = SAC_DATA_W'(s_ff.cfg.clock_divider_select);
                SAC_OFS_REFSRC:  nxt_s.rd_data = SAC_DATA_W'(s_ff.cfg.reference_select);
                SAC_OFS_SDELAY:  nxt_s.rd_data = SAC_DATA_W'(s_ff.cfg.sample_delay);
                SAC_OFS_SLENGTH: nxt_s.rd_data = SAC_DATA_W'(s_ff.cfg.sample_length);
                SAC_OFS_CHANNEL: nxt_s.rd_data = SAC_DATA_W'(s_ff.cfg.input_channel_select);
                SAC_OFS_COMMAND: nxt_s.rd_data = SAC_DATA_W'(s_ff.start_conversion_cmd);
                SAC_OFS_EVENT:   nxt_s.rd_data = SAC_DATA_W'(s_ff.cfg.event_start_enable);
                SAC_OFS_INTEN:   nxt_s.rd_data = SAC_DATA_W'(s_ff.cfg.ready_int_enable);
                SAC_OFS_FLAGS:   nxt_s.rd_data = SAC_DATA_W'(s_ff.result_ready_flag);
                SAC_OFS_RESULT: begin
                    nxt_s.rd_data           = s_ff.conversion_result;
                    nxt_s.result_ready_flag = 1'b0;
                end
                SAC_OFS_STATUS: begin
                    nxt_s.rd_data = SAC_DATA_W'(s_ff.phase != SAC_IDLE);
                    nxt_s.rd_data[SAC_STAT_CH_LSB +: SAC_CH_W] = s_ff.ch_act;
                end
                default:         nxt_s.rd_data = '0;
            endcase
        end

        // ****************************************************************
        // Event trigger
        // ****************************************************************
        if (ev_edge && s_ff.cfg.event_start_enable && s_ff.cfg.enable) begin
            nxt_s.start_conversion_cmd = 1'b1;
        end

        // ****************************************************************
        // Prescaler and conversion sequencer
        // ****************************************************************
        if (run && s_ff.phase != SAC_IDLE) begin
            nxt_s.pcnt = (s_ff.pcnt == wrap) ? '0 : s_ff.pcnt + 9'h001;
        end

        unique case (s_ff.phase)
            SAC_IDLE: begin
                // Leaving idle in the write cycle keeps the start latency fixed.
                if (nxt_s.start_conversion_cmd && run) begin
                    nxt_s.phase = SAC_WAIT;
                end
            end
            SAC_WAIT: begin
                if (tick) begin
                    nxt_s.phase = SAC_CONV;
                    nxt_s.cyc   = '0;
                    nxt_s.sar   = '0;
                end
            end
            SAC_CONV: begin
                if (tick) begin
                    if (s_ff.cyc == last_cyc) begin
                        nxt_s.cyc = '0;
                        nxt_s.sar = '0;
                        if (s_ff.nsamp == last_sample(s_ff.cfg.accumulation_count)) begin
                            nxt_s.conversion_result = sum;
                            nxt_s.acc   = '0;
                            nxt_s.nsamp = '0;
                            done        = 1'b1;
                            if (!s_ff.cfg.continuous_mode) begin
                                nxt_s.start_conversion_cmd = 1'b0;
                                nxt_s.phase = SAC_IDLE;
                            end
                        end else begin
                            nxt_s.acc   = sum;
                            nxt_s.nsamp = s_ff.nsamp + 7'h01;
                        end
                    end else begin
                        nxt_s.cyc = cyc_next;
                        if (cyc_next >= samp_len && cyc_next < last_cyc) begin
                            nxt_s.sar[bpos_next] = 1'b1;
                        end
                    end
                end else if (pre_tick && s_ff.cyc >= samp_len && s_ff.cyc < last_cyc) begin
                    // A low decision drops the trial bit; full scale keeps every bit.
                    if (!s_ff.cmp_s2) begin
                        nxt_s.sar[bpos_cur] = 1'b0;
                    end
                end
            end
            default: nxt_s.phase = SAC_IDLE;
        endcase

        if (!nxt_s.cfg.enable) begin
            nxt_s.phase                = SAC_IDLE;
            nxt_s.start_conversion_cmd = 1'b0;
            nxt_s.cyc                  = '0;
            nxt_s.nsamp                = '0;
            nxt_s.acc                  = '0;
            nxt_s.sar                  = '0;
        end
        if (nxt_s.phase == SAC_IDLE) begin
            nxt_s.pcnt = '0;
        end

        // Completion overrides a clear made in the same cycle.
        if (done) begin
            nxt_s.result_ready_flag = 1'b1;
        end

        // ****************************************************************
        // Channel and reference selection
        // ****************************************************************
        lock = (nxt_s.phase == SAC_CONV) && (nxt_s.cyc != last_cyc);
        if (nxt_s.cfg.enable && !lock) begin
            nxt_s.ch_act  = nxt_s.cfg.input_channel_select;
            nxt_s.ref_act = nxt_s.cfg.reference_select;
        end

        nxt_s.sample = (nxt_s.phase == SAC_CONV) && (nxt_s.cyc < samp_len);
        nxt_s.irq    = nxt_s.result_ready_flag && nxt_s.cfg.ready_int_enable
                       && global_int_enable_in;
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            s_ff <= SAC_STATE_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rd_data_out          = s_ff.rd_data;
    assign irq_out              = s_ff.irq;
    assign analog_out.enable    = s_ff.cfg.enable;
    assign analog_out.sample    = s_ff.sample;
    assign analog_out.trial     = s_ff.sar;
    assign analog_out.channel   = s_ff.ch_act;
    assign analog_out.reference = s_ff.ref_act;

endmodule

`default_nettype wire

// *** dv/sac_ctrl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_props (
    input wire logic                           clk_sys_in,
    input wire logic                           reset_in,
    input wire sac_pkg::sac_bus_req_t          bus_in,
    input wire logic [sac_pkg::SAC_DATA_W-1:0] rd_data_out,
    input wire logic                           event_in,
    input wire logic                           global_int_enable_in,
    input wire logic                           debug_halt_in,
    input wire logic                           irq_out,
    input wire logic                           cmp_in,
    input wire sac_pkg::sac_analog_t           analog_out
);
    import sac_pkg::*;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    property p_irq_gie; irq_out |-> $past(global_int_enable_in); endproperty
    a_irq_gie: assert property (p_irq_gie) else $error("irq without global enable");
    property p_irq_fall; $fell(irq_out) |-> $past(bus_in.rd || bus_in.wr || !global_int_enable_in); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
    property p_rd_idle; !$past(bus_in.rd) |-> rd_data_out == '0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_start_en; $rose(analog_out.sample) |-> analog_out.enable; endproperty
    a_start_en: assert property (p_start_en) else $error("sampling while disabled");
    property p_off; !analog_out.enable && !$past(analog_out.enable) |-> !analog_out.sample; endproperty
    a_off: assert property (p_off) else $error("sample strobe while off");
    property p_lock; analog_out.sample && $past(analog_out.sample) |-> $stable(analog_out.channel); endproperty
    a_lock: assert property (p_lock) else $error("channel moved in conversion");
    property p_trial; $fell(analog_out.sample) && analog_out.enable |-> analog_out.trial == 10'h200; endproperty
    a_trial: assert property (p_trial) else $error("first trial code wrong");
    property p_smin; $rose(analog_out.sample) |-> analog_out.sample [*8]; endproperty
    a_smin: assert property (p_smin) else $error("sampling too short");
    c_conv: cover property ($rose(analog_out.sample));
    c_irq: cover property ($rose(irq_out));
    c_mask: cover property ($fell(irq_out) && !global_int_enable_in);
endmodule
bind sac_ctrl sac_ctrl_props i_props (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .bus_in(bus_in),
    .rd_data_out(rd_data_out), .event_in(event_in), .global_int_enable_in(global_int_enable_in),
    .debug_halt_in(debug_halt_in), .irq_out(irq_out), .cmp_in(cmp_in), .analog_out(analog_out));
`default_nettype wire

// *** dv/sac_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sac_core_model (
    input  wire logic                 clk_sys_in,
    input  wire sac_pkg::sac_analog_t analog_in,
    input  wire logic [10:0]          level_in,
    output logic                      cmp_out
);
    logic [10:0] hold = '0;
    logic        tgl  = 1'b0;
    // The core tracks the input while the strobe is high and holds it from the falling edge on.
    always @(posedge clk_sys_in) begin
        tgl <= ~tgl;
        if (analog_in.sample) begin
            hold <= level_in;
        end
    end
    // A level above the reference beats every trial code, so it saturates at full scale.
    assign cmp_out = analog_in.enable ? (hold >= {1'b0, analog_in.trial}) : tgl;
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sac_pkg::*;
    logic                  clk_sys_in = 1'b0;
    logic                  reset_in   = 1'b1;
    sac_bus_req_t          bus        = '0;
    logic                  ev         = 1'b0;
    logic                  gie        = 1'b1;
    logic                  halt       = 1'b0;
    logic [10:0]           level      = '0;
    logic [SAC_DATA_W-1:0] rdd;
    logic [SAC_DATA_W-1:0] q;
    logic                  irq;
    logic                  cmp;
    sac_analog_t           ana;
    int                    fail_count  = 0;
    int                    check_count = 0;
    integer                seed        = 32'hf95fbaf7;
    int                    falls       = 0;
    int                    fac, dly, len, n, c1, c2, kp;
    int                    exp_q[$];
    always #10 clk_sys_in = ~clk_sys_in;
    always @(negedge ana.sample) falls++;
    sac_ctrl i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .bus_in(bus), .rd_data_out(rdd),
        .event_in(ev), .global_int_enable_in(gie), .debug_halt_in(halt), .irq_out(irq), .cmp_in(cmp),
        .analog_out(ana));
    sac_core_model i_core (.clk_sys_in(clk_sys_in), .analog_in(ana), .level_in(level), .cmp_out(cmp));
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_in);
        bus <= '0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_in);
        bus <= '0;
        #1;
        q = rdd;
    endtask
    task automatic wt(input int w, output int c);
        c = 0;
        do begin
            @(posedge clk_sys_in);
            #1;
            c++;
        end while (c < 3000 && (w == 0 ? ana.sample !== 1'b1 : w == 1 ? ana.sample !== 1'b0 : irq !== 1'b1));
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        rd(SAC_OFS_CTRL);
        check("ctrl", 16'h0000, q);
        rd(4'hE);
        check("unmapped", 16'h0000, q);
        wr(SAC_OFS_INTEN, 16'h0001);
        for (int i = 0; i < 8; i++) begin
            fac = 4 << (i % 2);
            dly = $random(seed) & 3;
            len = $random(seed) & 3;
            n = (i == 6) ? 2 : 0;
            kp = (i == 5) ? 1 : 0;
            level = 11'($random(seed));
            exp_q.push_back(((level > 11'h3FF) ? 1023 : int'(level)) << n);
            wr(SAC_OFS_DIVIDER, 16'(i % 2));
            wr(SAC_OFS_SDELAY, 16'(dly));
            wr(SAC_OFS_SLENGTH, 16'(len));
            wr(SAC_OFS_ACCUM, 16'(n));
            wr(SAC_OFS_REFSRC, 16'(i % 4));
            wr(SAC_OFS_CHANNEL, 16'(i));
            wr(SAC_OFS_EVENT, 16'(i % 3 == 2));
            wr(SAC_OFS_CTRL, 16'(1 + 8 * kp));
            falls = 0;
            // The trigger cycle itself counts towards the start latency.
            if (i % 3 == 2) begin
                ev <= 1'b1;
                wt(0, c1);
                check("event delay", 16'(fac / 2 + 5), 16'(c1 + 1));
            end else begin
                wr(SAC_OFS_COMMAND, 16'h0001);
                wt(0, c1);
                check("start delay", 16'(fac / 2 + 2), 16'(c1 + 1));
            end
            wr(SAC_OFS_CHANNEL, 16'(i + 8));
            halt <= 1'b1;
            repeat (5) @(posedge clk_sys_in);
            halt <= 1'b0;
            wt(1, c2);
            check("sampling", 16'((2 + dly + len) * fac + 5 * (1 - kp)), 16'(c2 + 6));
            check("locked channel", 16'(i), {11'h000, ana.channel});
            check("reference", 16'(i % 4), {14'h0, ana.reference});
            wt(2, c2);
            if (n == 0) check("tail", 16'(11 * fac), 16'(c2));
            check("samples", 16'(1 << n), 16'(falls));
            check("new channel", 16'(i + 8), {11'h000, ana.channel});
            rd(SAC_OFS_COMMAND);
            check("start bit", 16'h0000, q);
            if (i == 1) begin
                gie <= 1'b0;
                repeat (2) @(posedge clk_sys_in);
                #1;
                check("irq masked", 16'h0000, {15'h0000, irq});
                gie <= 1'b1;
                repeat (2) @(posedge clk_sys_in);
                #1;
                check("flag kept", 16'h0001, {15'h0000, irq});
                wr(SAC_OFS_FLAGS, 16'h0001);
                check("flag write clear", 16'h0000, {15'h0000, irq});
            end
            rd(SAC_OFS_RESULT);
            check("result", 16'(exp_q.pop_front()), q);
            check("irq cleared", 16'h0000, {15'h0000, irq});
            ev <= 1'b0;
        end
        wr(SAC_OFS_CTRL, 16'h0003);
        wr(SAC_OFS_COMMAND, 16'h0001);
        wt(0, c1);
        wt(1, c1);
        wt(0, c2);
        check("period", 16'((13 + dly + len) * fac), 16'(c1 + c2));
        rd(SAC_OFS_COMMAND);
        check("start bit held", 16'h0001, q);
        rd(SAC_OFS_STATUS);
        check("status", 16'h0F01, q);
        wt(1, c1);
        wr(SAC_OFS_CTRL, 16'h0000);
        give_verdict();
    end
    initial begin
        #1000000;
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
